// ---- verilog/rpc_pkg.sv ----
// Constants shared by the power control port design
`default_nettype none
package rpc_pkg;
    // Clock and strobe timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int STROBE_PERIOD_NS = 20000;
    localparam int STROBE_CYCLES_RAW = STROBE_PERIOD_NS / CLK_PERIOD_NS;
    localparam int STROBE_CYCLES = (STROBE_CYCLES_RAW < 1) ? 1 : STROBE_CYCLES_RAW;
    localparam int STROBE_CNT_W = 16;

    // Register byte offsets
    localparam logic [3:0] REG_DSP_CTRL = 4'h0;
    localparam logic [3:0] REG_MCU_CTRL = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h8;

    // Control register bits written by the DSP side
    localparam int DSP_TX_BIT = 0;
    localparam int DSP_IQ_BIT = 1;
    localparam int DSP_VOICE_FM_SELECT_BIT = 2;
    localparam int DSP_MODE_BIT = 3;
    localparam int DSP_PA_BIT = 4;
    localparam int DSP_W = 5;

    // Control/status register bits of the microcontroller side
    localparam int MCU_CODEC_BIT = 0;
    localparam int MCU_FM_BIT = 1;
    localparam int MCU_USER_BIT = 2;
    localparam int MCU_LOCK_BIT = 7;
    localparam int MCU_W = 3;

    // Status register bits: sampled controls and pin levels
    localparam int ST_TX_BIT = 0;
    localparam int ST_IQ_BIT = 1;
    localparam int ST_VOICE_FM_SELECT_BIT = 2;
    localparam int ST_MODE_BIT = 3;
    localparam int ST_PA_BIT = 4;
    localparam int ST_LOCK_BIT = 5;

    // Reset values
    localparam logic [DSP_W-1:0] DSP_RESET = 5'h00;
    localparam logic [MCU_W-1:0] MCU_RESET = 3'h0;

    // Transmit sample width
    localparam int TX_DATA_W = 10;
endpackage
`default_nettype wire

// ---- verilog/rpc_pin_sync.sv ----
// Three-stage pin synchroniser with agreement filter
`default_nettype none
module rpc_pin_sync
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Pin and filtered level
    input wire logic pin_in,
    output logic level
);
    logic s1;
    logic s2;
    logic s3;
    logic next_level;

    // Only the second and third stages vote; the first is metastability guard
    always_comb
    begin
        next_level = level;
        if (s2 == s3)
        begin
            next_level = s3;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            level <= 1'b0;
        end
        else
        begin
            s1 <= pin_in;
            s2 <= s1;
            s3 <= s2;
            level <= next_level;
        end
    end
endmodule
`default_nettype wire

// ---- verilog/rpc_strobe_gen.sv ----
// Internal periodic strobe generator
`default_nettype none
module rpc_strobe_gen
    import rpc_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // One-cycle strobe
    output logic strobe
);
    localparam logic [STROBE_CNT_W-1:0] LAST = STROBE_CNT_W'(STROBE_CYCLES - 1);

    logic [STROBE_CNT_W-1:0] count;
    logic [STROBE_CNT_W-1:0] next_count;
    logic next_strobe;

    always_comb
    begin
        next_strobe = 1'b0;
        next_count = count + 1'b1;
        if (count == LAST)
        begin
            next_count = '0;
            next_strobe = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            count <= '0;
            strobe <= 1'b0;
        end
        else
        begin
            count <= next_count;
            strobe <= next_strobe;
        end
    end
endmodule
`default_nettype wire

// ---- verilog/rpc_power_port.sv ----
// Power control port: enable outputs, receive routing, transmit gating
// Functional notes
// - Drive six active-high power enables from control register bits.
// - All six enables are low after reset until software sets them.
// - Voice-FM select routes Q positive to FM, Q negative to reference, powers Q.
// - Mode bit high selects digital Q filtering, low selects analog.
// - IQ receive enable powers both I and Q sides, even in analog mode.
// - Mode low routes Q positive pin to FM and Q negative pin to reference.
// - Sampled transmit enable switches on internal transmit functions.
// - Transmit enable low floats power control output and forces PA enable low.
// - Analog mode: PA enable equals transmit enable and synthesizer locked.
// - Transmit, IQ, voice-FM and mode controls sampled on each internal strobe.
// - Control writes do not reach sampled controls before the next strobe.
// - Out-of-lock zeroes I and Q transmit outputs and is readable as status.
//
// The implementer's own choices: the placing of the registers and the Avalon-MM interface to the registers.
`default_nettype none
module rpc_power_port
    import rpc_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Avalon-MM slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Synthesizer lock pin
    input wire logic synth_out_of_lock_in,
    // Transmit data path
    input wire logic [TX_DATA_W-1:0] tx_i_data,
    input wire logic [TX_DATA_W-1:0] tx_q_data,
    input wire logic tx_power_level,
    output logic [TX_DATA_W-1:0] tx_inphase_out,
    output logic [TX_DATA_W-1:0] tx_quadrature_out,
    output logic transmit_power_control_out,
    output logic transmit_power_control_oe,
    // External power enables
    output logic speech_codec_power_en,
    output logic fm_demod_power_en,
    output logic iq_receive_power_en,
    output logic transmit_power_en,
    output logic power_amp_en,
    output logic user_power_out,
    // Receiver controls and internal transmit enable
    output logic q_positive_to_fm,
    output logic q_negative_to_ref,
    output logic rx_q_side_power,
    output logic rx_i_side_power,
    output logic rx_q_filter_digital,
    output logic tx_internal_en
);
    logic strobe;
    logic lock_lost;

    rpc_strobe_gen u_strobe
    (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .strobe(strobe)
    );

    rpc_pin_sync u_lock_sync
    (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .pin_in(synth_out_of_lock_in),
        .level(lock_lost)
    );

    // Bus slave state
    logic ack;
    logic next_ack;
    logic [31:0] next_readdata;
    logic wr_take;

    // Register state
    logic [DSP_W-1:0] dsp_status_control_reg;
    logic [DSP_W-1:0] next_dsp;
    logic [MCU_W-1:0] mcu_status_control_reg;
    logic [MCU_W-1:0] next_mcu;

    // Sampled controls
    logic tx_s;
    logic iq_s;
    logic voice_fm_select_s;
    logic mode_s;
    logic pa_req_s;
    logic next_tx_s;
    logic next_iq_s;
    logic next_voice_fm_select_s;
    logic next_mode_s;
    logic next_pa_req_s;

    // Registered outputs
    logic next_pa;
    logic [TX_DATA_W-1:0] next_tx_i;
    logic [TX_DATA_W-1:0] next_tx_q;
    logic next_pwr_level;

    function automatic logic [31:0] status_word(input logic t, input logic iq, input logic fv,
                                                input logic md, input logic pa, input logic lk);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[ST_TX_BIT] = t;
        w[ST_IQ_BIT] = iq;
        w[ST_VOICE_FM_SELECT_BIT] = fv;
        w[ST_MODE_BIT] = md;
        w[ST_PA_BIT] = pa;
        w[ST_LOCK_BIT] = lk;
        return w;
    endfunction

    // One wait cycle per access: read data is caught before waitrequest drops
    assign avs_waitrequest = (avs_read | avs_write) & ~ack;
    assign wr_take = avs_write & ack;

    always_comb
    begin
        next_ack = (avs_read | avs_write) & ~ack;
        next_readdata = avs_readdata;
        if (avs_read && !ack)
        begin
            case (avs_address)
                REG_DSP_CTRL:
                begin
                    next_readdata = 32'(dsp_status_control_reg);
                end
                REG_MCU_CTRL:
                begin
                    next_readdata = 32'(mcu_status_control_reg);
                    next_readdata[MCU_LOCK_BIT] = lock_lost;
                end
                REG_STATUS:
                begin
                    next_readdata = status_word(tx_s, iq_s, voice_fm_select_s, mode_s, power_amp_en,
                                                lock_lost);
                end
                default:
                begin
                    next_readdata = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ack <= 1'b0;
            avs_readdata <= 32'h0000_0000;
        end
        else
        begin
            ack <= next_ack;
            avs_readdata <= next_readdata;
        end
    end

    // Register writes
    always_comb
    begin
        next_dsp = dsp_status_control_reg;
        next_mcu = mcu_status_control_reg;
        if (wr_take && avs_address == REG_DSP_CTRL)
        begin
            next_dsp = avs_writedata[DSP_W-1:0];
        end
        if (wr_take && avs_address == REG_MCU_CTRL)
        begin
            next_mcu = avs_writedata[MCU_W-1:0];
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            dsp_status_control_reg <= DSP_RESET;
            mcu_status_control_reg <= MCU_RESET;
        end
        else
        begin
            dsp_status_control_reg <= next_dsp;
            mcu_status_control_reg <= next_mcu;
        end
    end

    // Sampling on the strobe only; writes between strobes stay invisible
    always_comb
    begin
        next_tx_s = tx_s;
        next_iq_s = iq_s;
        next_voice_fm_select_s = voice_fm_select_s;
        next_mode_s = mode_s;
        next_pa_req_s = pa_req_s;
        if (strobe)
        begin
            next_tx_s = dsp_status_control_reg[DSP_TX_BIT];
            next_iq_s = dsp_status_control_reg[DSP_IQ_BIT];
            next_voice_fm_select_s = dsp_status_control_reg[DSP_VOICE_FM_SELECT_BIT];
            next_mode_s = dsp_status_control_reg[DSP_MODE_BIT];
            next_pa_req_s = dsp_status_control_reg[DSP_PA_BIT];
        end
    end

    // PA and transmit data follow the filtered lock level
    always_comb
    begin
        next_pa = tx_s & ~lock_lost & (~mode_s | pa_req_s);
        next_tx_i = lock_lost ? '0 : tx_i_data;
        next_tx_q = lock_lost ? '0 : tx_q_data;
        next_pwr_level = tx_power_level;
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            tx_s <= 1'b0;
            iq_s <= 1'b0;
            voice_fm_select_s <= 1'b0;
            mode_s <= 1'b0;
            pa_req_s <= 1'b0;
            power_amp_en <= 1'b0;
            tx_inphase_out <= '0;
            tx_quadrature_out <= '0;
            transmit_power_control_out <= 1'b0;
        end
        else
        begin
            tx_s <= next_tx_s;
            iq_s <= next_iq_s;
            voice_fm_select_s <= next_voice_fm_select_s;
            mode_s <= next_mode_s;
            pa_req_s <= next_pa_req_s;
            power_amp_en <= next_pa;
            tx_inphase_out <= next_tx_i;
            tx_quadrature_out <= next_tx_q;
            transmit_power_control_out <= next_pwr_level;
        end
    end

    // Enables are plain gates of flip-flops, so they stay glitch-free
    assign speech_codec_power_en = mcu_status_control_reg[MCU_CODEC_BIT];
    assign fm_demod_power_en = mcu_status_control_reg[MCU_FM_BIT];
    assign user_power_out = mcu_status_control_reg[MCU_USER_BIT];
    assign iq_receive_power_en = iq_s;
    assign transmit_power_en = tx_s;
    assign tx_internal_en = tx_s;
    assign transmit_power_control_oe = tx_s;
    assign q_positive_to_fm = voice_fm_select_s | ~mode_s;
    assign q_negative_to_ref = voice_fm_select_s | ~mode_s;
    assign rx_q_side_power = voice_fm_select_s | iq_s;
    assign rx_i_side_power = iq_s;
    assign rx_q_filter_digital = mode_s;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);

    property p_pa_needs_tx;
        power_amp_en |-> $past(tx_s);
    endproperty
    a_pa_needs_tx: assert property (p_pa_needs_tx)
        else $error("PA enable high without transmit enable");

    property p_pwr_float;
        !transmit_power_en |-> !transmit_power_control_oe ##1 !power_amp_en;
    endproperty
    a_pwr_float: assert property (p_pwr_float)
        else $error("Power control driven while transmit off");

    property p_pa_analog;
        (!mode_s && tx_s && !lock_lost) |=> power_amp_en;
    endproperty
    a_pa_analog: assert property (p_pa_analog)
        else $error("Analog PA enable not following transmit and lock");

    property p_pa_digital;
        (mode_s && tx_s && !lock_lost) |=> power_amp_en == $past(pa_req_s);
    endproperty
    a_pa_digital: assert property (p_pa_digital)
        else $error("Digital PA enable not following its bit");

    property p_sample_take;
        strobe |=> transmit_power_en == $past(dsp_status_control_reg[DSP_TX_BIT])
            && iq_receive_power_en == $past(dsp_status_control_reg[DSP_IQ_BIT])
            && rx_q_filter_digital == $past(dsp_status_control_reg[DSP_MODE_BIT]);
    endproperty
    a_sample_take: assert property (p_sample_take)
        else $error("Sampled controls not taken on strobe");

    property p_sample_hold;
        !strobe |=> $stable(transmit_power_en) && $stable(iq_receive_power_en)
            && $stable(voice_fm_select_s) && $stable(rx_q_filter_digital);
    endproperty
    a_sample_hold: assert property (p_sample_hold)
        else $error("Sampled control changed without strobe");

    property p_voice_fm_select_route;
        voice_fm_select_s |-> q_positive_to_fm && q_negative_to_ref && rx_q_side_power;
    endproperty
    a_voice_fm_select_route: assert property (p_voice_fm_select_route)
        else $error("Voice-FM select did not route Q side");

    property p_mode_route;
        !rx_q_filter_digital |-> q_positive_to_fm && q_negative_to_ref;
    endproperty
    a_mode_route: assert property (p_mode_route)
        else $error("Analog mode did not route Q pins");

    property p_iq_power;
        iq_receive_power_en |-> rx_i_side_power && rx_q_side_power;
    endproperty
    a_iq_power: assert property (p_iq_power)
        else $error("IQ enable did not power both sides");

    property p_lock_zero;
        lock_lost |=> tx_inphase_out == '0 && tx_quadrature_out == '0 && !power_amp_en;
    endproperty
    a_lock_zero: assert property (p_lock_zero)
        else $error("Transmit data not zeroed while out of lock");

    property p_codec_write;
        (wr_take && avs_address == REG_MCU_CTRL)
            |=> speech_codec_power_en == $past(avs_writedata[MCU_CODEC_BIT])
            && fm_demod_power_en == $past(avs_writedata[MCU_FM_BIT])
            && user_power_out == $past(avs_writedata[MCU_USER_BIT]);
    endproperty
    a_codec_write: assert property (p_codec_write)
        else $error("Direct enable did not follow write");

    c_tx_on: cover property (strobe ##1 transmit_power_en);
    c_pa_analog: cover property (power_amp_en && !mode_s);
    c_pa_digital: cover property (power_amp_en && mode_s);
    c_lock_lost: cover property (tx_s && lock_lost ##1 !power_amp_en);
endmodule
`default_nettype wire

// ---- testbench/rpc_radio_model.sv ----
// Radio-side partner: synthesizer lock pin and pulled-down power control line
`default_nettype none
module rpc_radio_model
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Bench command: synthesizer loses lock
    input wire logic lock_fail,
    // Power control pin as driven by the port
    input wire logic pwr_ctrl_out,
    input wire logic pwr_ctrl_oe,
    // Lock indicator and resolved pin level
    output logic synth_out_of_lock_in,
    output logic pwr_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    // Lock flag moves just after an edge, like an external OR of lock detectors
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            synth_out_of_lock_in <= 1'b0;
        else
            synth_out_of_lock_in <= lock_fail;
    end
    // Pull-down: a floated line reads low, never the last driven value
    assign pwr_pin = pwr_ctrl_oe ? pwr_ctrl_out : 1'b0;
endmodule
`default_nettype wire

// ---- testbench/tb_top.sv ----
// Self-checking bench for the power control port
`default_nettype none
module tb_top
    import rpc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk, reset_n, avs_read, avs_write, avs_waitrequest, lock_fail;
    logic [3:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic synth_out_of_lock_in, tx_power_level, pwr_pin, tx_internal_en;
    logic [TX_DATA_W-1:0] tx_i_data, tx_q_data, tx_inphase_out, tx_quadrature_out;
    logic transmit_power_control_out, transmit_power_control_oe;
    logic speech_codec_power_en, fm_demod_power_en, iq_receive_power_en;
    logic transmit_power_en, power_amp_en, user_power_out;
    logic q_positive_to_fm, q_negative_to_ref, rx_q_side_power, rx_i_side_power;
    logic rx_q_filter_digital;
    logic [5:0] en_vec;
    logic [7:0] rx_vec;
    logic [5:0] mcu_map [3] = '{6'h20, 6'h10, 6'h01};
    int num_errors = 0;
    int check_count = 0;

    assign en_vec = {speech_codec_power_en, fm_demod_power_en, iq_receive_power_en,
        transmit_power_en, power_amp_en, user_power_out};
    assign rx_vec = {power_amp_en, rx_i_side_power, rx_q_side_power, rx_q_filter_digital,
        q_positive_to_fm, q_negative_to_ref, transmit_power_control_oe, pwr_pin};

    rpc_power_port u_rpc_power_port (.ref_clk(ref_clk), .reset_n(reset_n),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .synth_out_of_lock_in(synth_out_of_lock_in),
        .tx_i_data(tx_i_data), .tx_q_data(tx_q_data), .tx_power_level(tx_power_level),
        .tx_inphase_out(tx_inphase_out), .tx_quadrature_out(tx_quadrature_out),
        .transmit_power_control_out(transmit_power_control_out),
        .transmit_power_control_oe(transmit_power_control_oe),
        .speech_codec_power_en(speech_codec_power_en), .fm_demod_power_en(fm_demod_power_en),
        .iq_receive_power_en(iq_receive_power_en), .transmit_power_en(transmit_power_en),
        .power_amp_en(power_amp_en), .user_power_out(user_power_out),
        .q_positive_to_fm(q_positive_to_fm), .q_negative_to_ref(q_negative_to_ref),
        .rx_q_side_power(rx_q_side_power), .rx_i_side_power(rx_i_side_power),
        .rx_q_filter_digital(rx_q_filter_digital), .tx_internal_en(tx_internal_en));

    rpc_radio_model u_rpc_radio_model (.ref_clk(ref_clk), .reset_n(reset_n),
        .lock_fail(lock_fail), .pwr_ctrl_out(transmit_power_control_out),
        .pwr_ctrl_oe(transmit_power_control_oe),
        .synth_out_of_lock_in(synth_out_of_lock_in), .pwr_pin(pwr_pin));

    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    task automatic results();
        if (num_errors == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One bus transfer; request held until waitrequest is seen low at an edge
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int n;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        n = 0;
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0 && n < 20)
        begin
            @(posedge ref_clk);
            n++;
        end
        q = avs_readdata;
        if (n == 20)
        begin
            num_errors++;
            results();
        end
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        // Gap edge so the next request is not driven in the same step
        @(posedge ref_clk);
    endtask

    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic reg_read(input string name, input logic [3:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(name, exp, q);
    endtask

    // Strobe period is 1000 cycles; margin covers the two-edge PA path
    task automatic wait_strobe();
        repeat (1003) @(posedge ref_clk);
    endtask

    task automatic wait_lock();
        repeat (8) @(posedge ref_clk);
    endtask

    initial
    begin
        reset_n = 1'b0;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        lock_fail = 1'b0;
        tx_i_data = 10'h2a5;
        tx_q_data = 10'h15a;
        tx_power_level = 1'b1;
        repeat (4) @(posedge ref_clk);
        reset_n <= 1'b1;
        @(posedge ref_clk);
        check("enables", 32'h0, 32'(en_vec));
        reg_read("dsp reg", REG_DSP_CTRL, 32'h0);
        reg_read("mcu reg", REG_MCU_CTRL, 32'h0);
        for (int i = 0; i < 3; i++)
        begin
            reg_write(REG_MCU_CTRL, 32'h1 << i);
            check("enables", 32'(mcu_map[i]), 32'(en_vec));
            reg_read("mcu reg", REG_MCU_CTRL, 32'h1 << i);
        end
        reg_write(REG_MCU_CTRL, 32'h7);
        // Unmapped and read-only places must not take writes
        reg_write(4'hc, 32'hffff_ffff);
        reg_write(REG_STATUS, 32'hff);
        reg_read("unmapped", 4'hc, 32'h0);
        reg_read("status", REG_STATUS, 32'h0);
        reg_read("mcu reg", REG_MCU_CTRL, 32'h7);
        reg_write(REG_DSP_CTRL, 32'h01);
        check("enables", 32'h31, 32'(en_vec));
        reg_read("status", REG_STATUS, 32'h0);
        reg_read("dsp reg", REG_DSP_CTRL, 32'h1);
        wait_strobe();
        check("enables", 32'h37, 32'(en_vec));
        check("rx analog", 32'h8f, 32'(rx_vec));
        check("tx internal", 32'h1, 32'(tx_internal_en));
        check("tx i", 32'(tx_i_data), 32'(tx_inphase_out));
        check("tx q", 32'(tx_q_data), 32'(tx_quadrature_out));
        // Pin must carry the level input, not just the enable
        tx_power_level <= 1'b0;
        repeat (2) @(posedge ref_clk);
        check("pwr pin", 32'h0, 32'(pwr_pin));
        tx_power_level <= 1'b1;
        reg_read("status", REG_STATUS, 32'h11);
        lock_fail <= 1'b1;
        wait_lock();
        check("pa", 32'h0, 32'(power_amp_en));
        check("tx i", 32'h0, 32'(tx_inphase_out));
        check("tx q", 32'h0, 32'(tx_quadrature_out));
        reg_read("mcu reg", REG_MCU_CTRL, 32'h87);
        reg_read("status", REG_STATUS, 32'h21);
        lock_fail <= 1'b0;
        wait_lock();
        check("pa", 32'h1, 32'(power_amp_en));
        reg_write(REG_DSP_CTRL, 32'h0b);
        wait_strobe();
        check("rx digital", 32'h73, 32'(rx_vec));
        reg_write(REG_DSP_CTRL, 32'h1b);
        wait_strobe();
        check("rx digital", 32'hf3, 32'(rx_vec));
        lock_fail <= 1'b1;
        wait_lock();
        check("rx digital", 32'h73, 32'(rx_vec));
        lock_fail <= 1'b0;
        reg_write(REG_DSP_CTRL, 32'h1c);
        wait_strobe();
        check("rx fm", 32'h3c, 32'(rx_vec));
        check("enables", 32'h31, 32'(en_vec));
        check("tx internal", 32'h0, 32'(tx_internal_en));
        // Reset in mid-run must clear every enable again
        reset_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        check("enables", 32'h0, 32'(en_vec));
        reset_n <= 1'b1;
        @(posedge ref_clk);
        check("enables", 32'h0, 32'(en_vec));
        check("oe", 32'h0, 32'(transmit_power_control_oe));
        results();
    end
endmodule
`default_nettype wire
